// ---- rtl/pes_top.sv ----
// pulse generator and saturating edge scaler array with a simple register port
module pes_top
  import pes_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic              global_clk_in,
  input  wire logic              switch_slot_b_sync,
  input  wire logic              switch_slot_b_trig1,
  input  wire logic              switch_slot_b_trig2,
  input  wire logic [1:0]        front_panel_nim_out,
  input  wire logic [4:0]        front_panel_diff_in,
  input  wire logic [4:0]        front_panel_diff_out,
  input  wire logic              busy_in,
  input  wire logic [7:0]        rear_connector_in,
  input  wire logic [7:0]        rear_connector_out,
  output logic                   pulse_out
);

  // register decode
  logic        hit_interval;
  logic        hit_low;
  logic        hit_repeat;
  logic        hit_launch;
  logic        hit_idle;
  logic        hit_freeze;
  logic        hit_count;
  logic [23:0] count_ofs;
  logic [5:0]  count_idx;

  assign hit_interval = (reg_addr == OFS_INTERVAL);
  assign hit_low      = (reg_addr == OFS_LOW);
  assign hit_repeat   = (reg_addr == OFS_REPEAT);
  assign hit_launch   = (reg_addr == OFS_LAUNCH); // R1
  assign hit_idle     = (reg_addr == OFS_IDLE);
  assign hit_freeze   = (reg_addr == OFS_FREEZE);
  assign count_ofs    = reg_addr - OFS_COUNTERS;
  assign count_idx    = count_ofs[7:2];
  // the array starts at its base and each word is one counter
  assign hit_count    = (reg_addr >= OFS_COUNTERS) && (count_ofs[1:0] == 2'b00) &&
                        (count_ofs[23:2] < 22'(NUM_COUNTERS)); // R7

  // settings registers
  logic [31:0] interval_ticks;
  logic [31:0] low_ticks;
  logic [31:0] repeat_total;
  logic        freeze;
  logic [31:0] next_interval_ticks;
  logic [31:0] next_low_ticks;
  logic [31:0] next_repeat_total;
  logic        next_freeze;
  logic        clear_counts;

  // software writes; leaving freeze is what zeroes the array
  always_comb begin
    next_interval_ticks = interval_ticks;
    next_low_ticks      = low_ticks;
    next_repeat_total   = repeat_total;
    next_freeze         = freeze;
    clear_counts        = 1'b0;
    if (reg_wr && hit_interval) begin
      next_interval_ticks = reg_wdata; // R18
    end
    if (reg_wr && hit_low) begin
      next_low_ticks = reg_wdata; // R19
    end
    if (reg_wr && hit_repeat) begin
      next_repeat_total = reg_wdata; // R20
    end
    if (reg_wr && hit_freeze) begin
      next_freeze  = reg_wdata[FREEZE_BIT]; // R4
      clear_counts = freeze && !reg_wdata[FREEZE_BIT]; // R5
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      interval_ticks <= REG_RESET;
      low_ticks      <= REG_RESET;
      repeat_total   <= REG_RESET;
      freeze         <= 1'b0;
    end else begin
      interval_ticks <= next_interval_ticks;
      low_ticks      <= next_low_ticks;
      repeat_total   <= next_repeat_total;
      freeze         <= next_freeze;
    end
  end

  // pulser: one tick per core clock, a finite train runs only after a launch
  pes_pulse_state_type pulse_state;
  pes_pulse_state_type next_pulse_state;
  logic [31:0] phase;
  logic [31:0] next_phase;
  logic [31:0] delivered;
  logic [31:0] next_delivered;
  logic        pulser_running;
  logic        period_end;
  logic        next_pulse_out;

  assign pulser_running = (repeat_total != REG_RESET) &&
                          ((repeat_total == REPEAT_FOREVER) || (pulse_state == PES_PULSE_RUN)); // R20
  // a period of zero or one ticks is treated as one tick long
  assign period_end     = (phase + 32'h00000001 >= interval_ticks);

  always_comb begin
    next_pulse_state = pulse_state;
    next_phase       = phase;
    next_delivered   = delivered;
    if (reg_wr && hit_launch) begin
      next_pulse_state = PES_PULSE_RUN; // R1 R21
      next_phase       = REG_RESET;
      next_delivered   = REG_RESET;
    end else if (pulser_running) begin
      if (period_end) begin
        next_phase     = REG_RESET;
        next_delivered = delivered + 32'h00000001;
        // finite trains stop after the last whole period
        if ((repeat_total != REPEAT_FOREVER) && (delivered + 32'h00000001 >= repeat_total)) begin
          next_pulse_state = PES_PULSE_STOP;
        end
      end else begin
        next_phase = phase + 32'h00000001;
      end
    end else begin
      // a zeroed count also ends any train in flight, so a later finite count needs a launch
      next_pulse_state = PES_PULSE_STOP; // R20 R21
      next_phase       = REG_RESET;
    end
    // low for the first part of the period, high for the rest
    next_pulse_out = pulser_running && (next_phase >= low_ticks); // R19
    case (next_pulse_state)
      PES_PULSE_RUN:  next_pulse_out = next_pulse_out;
      PES_PULSE_STOP: next_pulse_out = next_pulse_out && (repeat_total == REPEAT_FOREVER);
      default:        next_pulse_out = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pulse_state <= PES_PULSE_STOP;
      phase       <= REG_RESET;
      delivered   <= REG_RESET;
      pulse_out   <= 1'b0;
    end else begin
      pulse_state <= next_pulse_state;
      phase       <= next_phase;
      delivered   <= next_delivered;
      pulse_out   <= next_pulse_out;
    end
  end

  // reference tick divider, one enable pulse every four core cycles
  logic [1:0] ref_div;
  logic [1:0] next_ref_div;
  logic       ref_tick;

  assign ref_tick = (ref_div == REF_DIV_LAST);

  always_comb begin
    next_ref_div = ref_tick ? 2'h0 : ref_div + 2'h1;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ref_div <= 2'h0;
    end else begin
      ref_div <= next_ref_div;
    end
  end

  // two-stage synchroniser and one history stage for edge detection
  logic [NUM_EXT-1:0] ext_raw;
  logic [NUM_EXT-1:0] ext_meta;
  logic [NUM_EXT-1:0] ext_sync;
  logic [NUM_EXT-1:0] ext_prev;
  logic [NUM_EXT-1:0] ext_rise;

  assign ext_raw  = {rear_connector_out, rear_connector_in, busy_in, front_panel_diff_out,
                     front_panel_diff_in, front_panel_nim_out, switch_slot_b_trig2,
                     switch_slot_b_trig1, switch_slot_b_sync, global_clk_in};
  // rising transitions only, one pulse per transition
  assign ext_rise = ext_sync & ~ext_prev; // R22

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_meta <= '0;
      ext_sync <= '0;
      ext_prev <= '0;
    end else begin
      ext_meta <= ext_raw; // R22
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // increment requests in counter index order
  logic [NUM_COUNTERS-1:0] count_inc;

  assign count_inc[IDX_REF]       = ref_tick; // R8
  // the global clock is slower than the core, so it is sampled; a stopped clock adds nothing
  assign count_inc[IDX_GLOBAL]    = ext_rise[EXT_GCLK]; // R9
  assign count_inc[4:2]           = ext_rise[3:1]; // R10
  assign count_inc[6:5]           = ext_rise[5:4]; // R11
  assign count_inc[11:7]          = ext_rise[10:6]; // R12
  assign count_inc[16:12]         = ext_rise[15:11]; // R13
  assign count_inc[IDX_BUSY_EDGE] = ext_rise[EXT_BUSY]; // R14
  assign count_inc[IDX_BUSY_TIME] = ref_tick && ext_sync[EXT_BUSY]; // R15
  assign count_inc[26:19]         = ext_rise[24:17]; // R16
  assign count_inc[34:27]         = ext_rise[32:25]; // R17

  // counter array
  logic [31:0] counts      [NUM_COUNTERS];
  logic [31:0] next_counts [NUM_COUNTERS];

  always_comb begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      next_counts[i] = counts[i];
      if (clear_counts) begin
        next_counts[i] = REG_RESET; // R5
      end else if (!freeze && count_inc[i] && (counts[i] != COUNT_SAT)) begin
        next_counts[i] = counts[i] + 32'h00000001; // R4 R6
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        counts[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        counts[i] <= next_counts[i];
      end
    end
  end

  // read path, answered one cycle after the read strobe; unmapped reads give zero
  logic [31:0] next_reg_rdata;

  always_comb begin
    next_reg_rdata = REG_RESET;
    if (hit_interval) begin
      next_reg_rdata = interval_ticks;
    end else if (hit_low) begin
      next_reg_rdata = low_ticks;
    end else if (hit_repeat) begin
      next_reg_rdata = repeat_total;
    end else if (hit_idle) begin
      next_reg_rdata[IDLE_BIT] = !pulser_running; // R2 R3
    end else if (hit_freeze) begin
      next_reg_rdata[FREEZE_BIT] = freeze;
    end else if (hit_count) begin
      next_reg_rdata = counts[count_idx]; // R7
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata  <= REG_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? next_reg_rdata : REG_RESET;
      reg_rvalid <= reg_rd;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_launch_clears: assert property (reg_wr && hit_launch |=> delivered == REG_RESET && phase == REG_RESET) // R1
    else $error("launch did not clear pulse count");
  a_idle_busy: assert property (pulse_state == PES_PULSE_RUN && repeat_total != REG_RESET
                                |-> next_reg_rdata[IDLE_BIT] == 1'b0 || !hit_idle) // R2
    else $error("idle flag set while pulses remain");
  a_idle_disabled: assert property (repeat_total == REG_RESET && hit_idle |-> next_reg_rdata == 32'h00000001) // R3
    else $error("idle flag clear while pulser disabled");
  a_freeze_holds: assert property (freeze && !(reg_wr && hit_freeze) |=> counts[IDX_REF] == $past(counts[IDX_REF])) // R4
    else $error("counter moved while frozen");
  a_unfreeze_clears: assert property (freeze && reg_wr && hit_freeze && !reg_wdata[FREEZE_BIT]
                                      |=> counts[IDX_BUSY_TIME] == REG_RESET && !freeze) // R5
    else $error("unfreeze did not zero counters");
  a_saturate_holds: assert property (counts[IDX_REF] == COUNT_SAT && !clear_counts |=> counts[IDX_REF] == COUNT_SAT) // R6
    else $error("counter wrapped past all ones");
  a_ref_rate: assert property (!freeze && !clear_counts && counts[IDX_REF] != COUNT_SAT && ref_tick
                               |=> !ref_tick [*3] ##1 ref_tick) // R8
    else $error("reference tick spacing wrong");
  a_busy_edge_once: assert property (count_inc[IDX_BUSY_EDGE] |=> !count_inc[IDX_BUSY_EDGE]) // R14
    else $error("busy edge counted twice");
  a_finite_stops: assert property (pulse_state == PES_PULSE_RUN && repeat_total != REPEAT_FOREVER &&
                                   period_end && delivered + 32'h00000001 >= repeat_total && !(reg_wr && hit_launch)
                                   |=> pulse_state == PES_PULSE_STOP && !pulse_out) // R20
    else $error("finite pulse train did not stop");

endmodule

// ---- rtl/pes_pkg.sv ----
// constants and register map for the pulser and edge scaler block
// Notes on behaviour
// R1: any write to pulse_launch starts the pulser and zeroes the delivered-pulse count.
// R2: pulse_train_idle bit 0 reads 0 while requested pulses are still being emitted.
// R3: pulse_train_idle reads 1 when pulser disabled or finite sequence finished.
// R4: counter_freeze bit 0 set stops all counters; software sets it before readout.
// R5: clearing counter_freeze re-enables counting and zeroes every counter; done after readout.
// R6: counters are 32 bits and hold at all ones instead of wrapping.
// R7: counter array starts at 0x104; each index counts its own fixed source.
// R8: index 0 counts 50 MHz reference ticks since counting was enabled.
// R9: index 1 counts global clock cycles; no advance when that clock is absent.
// R10: indices 2 to 4 count edges of backplane sync, trigger 1, trigger 2.
// R11: indices 5 and 6 count edges of front panel NIM outputs 0 and 1.
// R12: indices 7 to 11 count edges of front panel differential inputs 0 to 4.
// R13: indices 12 to 16 count edges of front panel differential outputs 0 to 4.
// R14: index 17 counts busy assertions, once per rising busy edge.
// R15: index 18 counts 50 MHz ticks during which busy is high.
// R16: indices 19 to 26 count edges of rear connector inputs 0 to 7.
// R17: indices 27 to 34 count edges of rear connector outputs 0 to 7.
// R18: pulse_interval_ticks gives the whole pulse period in ticks.
// R19: pulse_low_ticks gives ticks held low each period; high for the rest.
// R20: pulse_repeat_total zero disables, middle values finite, all ones repeats forever.
// R21: for a finite count software must write pulse_launch to begin.
// R22: external inputs are synchronised; only rising transitions count, once each.
package pes_pkg;
  localparam int          ADDR_W          = 24;
  localparam int          DATA_W          = 32;
  localparam int          NUM_COUNTERS    = 35;
  localparam int          NUM_EXT         = 33;
  localparam logic [23:0] OFS_INTERVAL    = 24'h000080;
  localparam logic [23:0] OFS_LOW         = 24'h000084;
  localparam logic [23:0] OFS_REPEAT      = 24'h000088;
  localparam logic [23:0] OFS_LAUNCH      = 24'h00008C;
  localparam logic [23:0] OFS_IDLE        = 24'h000090;
  localparam logic [23:0] OFS_FREEZE      = 24'h000100;
  localparam logic [23:0] OFS_COUNTERS    = 24'h000104;
  localparam int          IDLE_BIT        = 0;
  localparam int          FREEZE_BIT      = 0;
  localparam logic [31:0] REG_RESET       = 32'h00000000;
  localparam logic [31:0] COUNT_SAT       = 32'hFFFFFFFF;
  localparam logic [31:0] REPEAT_FOREVER  = 32'hFFFFFFFF;
  localparam int          CORE_MHZ        = 200;
  localparam int          REF_MHZ         = 50;
  localparam int          REF_DIV         = CORE_MHZ / REF_MHZ;
  localparam logic [1:0]  REF_DIV_LAST    = 2'(REF_DIV - 1);
  // counter indices of the sources outside the line groups; busy has two counters
  localparam int          IDX_REF         = 0;
  localparam int          IDX_GLOBAL      = 1;
  localparam int          IDX_BUSY_EDGE   = 17;
  localparam int          IDX_BUSY_TIME   = 18;
  // positions inside the synchronised external vector
  localparam int          EXT_GCLK        = 0;
  localparam int          EXT_BUSY        = 16;
  typedef enum logic [0:0] {
    PES_PULSE_STOP = 1'b0,
    PES_PULSE_RUN  = 1'b1
  } pes_pulse_state_type;
endpackage

// ---- verif/pes_lines.sv ----
// far-side signal lines: one clean pulse on each requested line
module pes_lines (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [32:0] fire,
  output logic      [32:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;
  // high four cycles then low four, so a busy window always holds exactly one ref tick
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase <= 3'h0;
      lines <= '0;
    end else if (fire != '0) begin
      phase <= 3'h1;
      lines <= fire;
    end else if (phase != 3'h0) begin
      phase <= phase + 3'h1;
      if (phase == 3'h4) begin
        lines <= '0;
      end
    end
  end
endmodule

// ---- verif/test_pes_top.sv ----
// self-checking bench for the pulser and edge scaler block
module test_pes_top
  import pes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        reset;
  logic        reg_wr;
  logic        reg_rd;
  logic [23:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        pulse_out;
  logic [32:0] fire;
  logic [32:0] lines;
  logic [32:0] mask;
  logic [31:0] exp_q[$];
  logic [31:0] exp_cnt [NUM_COUNTERS];
  int          err_count;
  int          check_count;
  int          seed;

  pes_top pes_top_i (
    .core_clk             (core_clk),
    .reset                (reset),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .reg_rvalid           (reg_rvalid),
    .global_clk_in        (lines[0]),
    .switch_slot_b_sync   (lines[1]),
    .switch_slot_b_trig1  (lines[2]),
    .switch_slot_b_trig2  (lines[3]),
    .front_panel_nim_out  (lines[5:4]),
    .front_panel_diff_in  (lines[10:6]),
    .front_panel_diff_out (lines[15:11]),
    .busy_in              (lines[16]),
    .rear_connector_in    (lines[24:17]),
    .rear_connector_out   (lines[32:25]),
    .pulse_out            (pulse_out)
  );

  pes_lines pes_lines_i (
    .core_clk (core_clk),
    .reset    (reset),
    .fire     (fire),
    .lines    (lines)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [23:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // the expected word is noted before the strobe goes out
  task automatic reg_read(input logic [23:0] addr, input logic [31:0] exp);
    exp_q.push_back(exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic fire_lines(input logic [32:0] m);
    @(posedge core_clk);
    fire <= m;
    @(posedge core_clk);
    fire <= '0;
    repeat (10) @(posedge core_clk);
  endtask

  // read answers stand one cycle, so look mid-cycle
  always @(negedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected at %0t: read answer with none pending", $time);
      end else begin
        compare(reg_rdata, exp_q.pop_front(), "read");
      end
    end
  end

  initial begin
    #50us;
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin
    reset     = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    fire      = '0;
    seed      = 8;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      exp_cnt[i] = '0;
    end
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, write-only launch and an unmapped hole read back zero, except idle which reads one
    reg_read(OFS_INTERVAL, REG_RESET);
    reg_read(OFS_LOW, REG_RESET);
    reg_read(OFS_REPEAT, REG_RESET);
    reg_read(OFS_LAUNCH, REG_RESET);
    reg_read(OFS_FREEZE, REG_RESET);
    reg_read(OFS_IDLE, 32'h1);
    reg_read(24'h000200, REG_RESET);
    // finite train of two periods, low one tick of four
    reg_write(OFS_INTERVAL, 32'h4);
    reg_write(OFS_LOW, 32'h1);
    reg_write(OFS_REPEAT, 32'h2);
    reg_read(OFS_REPEAT, 32'h2);
    reg_write(OFS_LAUNCH, $random(seed));
    for (int k = 1; k <= 9; k++) begin
      @(posedge core_clk);
      #1;
      // after edge k the output shows tick k of the train; tick 0 already stood after the launch edge
      compare(32'(pulse_out), 32'(k < 8 && k % 4 >= 1), "pulse");
    end
    reg_read(OFS_IDLE, 32'h1);
    // relaunch on the edge where the train would stop: it restarts, so idle stays low past the first end
    reg_write(OFS_LAUNCH, 32'h0);
    reg_read(OFS_IDLE, 32'h0);
    repeat (4) @(posedge core_clk);
    reg_write(OFS_LAUNCH, 32'h0);
    reg_read(OFS_IDLE, 32'h0);
    repeat (12) @(posedge core_clk);
    reg_read(OFS_IDLE, 32'h1);
    // endless mode runs without launch; zero stops it at once
    reg_write(OFS_REPEAT, REPEAT_FOREVER);
    repeat (20) @(posedge core_clk);
    reg_read(OFS_IDLE, 32'h0);
    reg_write(OFS_REPEAT, 32'h0);
    @(posedge core_clk);
    #1;
    compare(32'(pulse_out), 32'h0, "pulse off");
    reg_read(OFS_IDLE, 32'h1);
    // freeze then release clears, then random edges on every line
    reg_write(OFS_FREEZE, 32'h1);
    reg_read(OFS_FREEZE, 32'h1);
    reg_write(OFS_FREEZE, 32'h0);
    for (int k = 0; k < 40; k++) begin
      mask = {1'($random(seed)), 32'($random(seed))};
      fire_lines(mask);
      for (int i = 0; i < NUM_EXT; i++) begin
        // lines above busy skip the busy-time counter in the index map
        if (mask[i]) begin
          exp_cnt[i + ((i > EXT_BUSY) ? 2 : 1)]++;
        end
      end
      if (mask[EXT_BUSY]) begin
        exp_cnt[IDX_BUSY_TIME]++;
      end
    end
    reg_write(OFS_FREEZE, 32'h1);
    fire_lines('1);
    for (int i = IDX_GLOBAL; i < NUM_COUNTERS; i++) begin
      reg_read(OFS_COUNTERS + 24'(4 * i), exp_cnt[i]);
    end
    reg_write(OFS_FREEZE, 32'h0);
    for (int i = IDX_GLOBAL; i < NUM_COUNTERS; i++) begin
      reg_read(OFS_COUNTERS + 24'(4 * i), 32'h0);
    end
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule
